// [bench/pei_np.sv]
// node processor model: avalon-mm master of the event unit
module pei_np (
   // clock
   input  wire logic        clk_sys,
   // avalon-mm master side
   output logic      [7:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [3:0]  avs_byteenable,
   output logic      [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {avs_address, avs_read, avs_write} = '0;
      {avs_byteenable, avs_writedata} = '0;
   end
   // request held until waitrequest is seen low; no latency assumed
   task automatic xfer(input logic [5:0] idx, input logic w,
                       input logic [15:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      avs_address    <= {idx, 2'b00};
      avs_read       <= !w;
      avs_write      <= w;
      avs_writedata  <= {16'h0000, wd};
      avs_byteenable <= 4'h3;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // interrupt service: one read returns the flags and clears only those it returned
   task automatic svc(output logic [31:0] rd);
      xfer(6'h17, 1'b0, 16'h0000, rd);
   endtask
endmodule

// [bench/pei_unit_properties.sv]
// port checker of the event interrupt unit, bound into pei_unit
module pei_props (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        ce,
   // register bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pins
   input wire logic        int_n,
   input wire logic        signal_detect_pin,
   input wire logic        self_test_complete
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // shadows follow accepted writes only, so they match the device state
   logic [15:0] mask_m;
   logic [3:0]  ctrl_m;
   logic        acc_w;
   logic [5:0]  idx;
   assign idx   = avs_address[7:2];
   assign acc_w = ce && avs_write && !avs_waitrequest;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_m <= 16'h0000;
         ctrl_m <= 4'h0;
      end else if (acc_w) begin
         if (idx == 6'h02 && avs_byteenable[0])
            mask_m[7:0] <= avs_writedata[7:0];
         if (idx == 6'h02 && avs_byteenable[1])
            mask_m[15:8] <= avs_writedata[15:8];
         if (idx == 6'h00 && avs_byteenable[0])
            ctrl_m <= avs_writedata[3:0];
      end
   end
   a_wait_one: assert property (
      (ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_pulse: assert property (
      (ce && !avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_mask_read: assert property (
      (ce && avs_read && avs_waitrequest && idx == 6'h02)
      |=> avs_readdata == {16'h0000, mask_m}) else $error("mask read wrong");
   a_mask_quiet: assert property (
      (mask_m == 16'h0000 && !ctrl_m[0]) |-> int_n)
      else $error("interrupt with all mask bits clear");
   a_st_block: assert property (
      (ctrl_m[0] && int_n && !self_test_complete) |=> (int_n || !ctrl_m[0]))
      else $error("event reached pin during self test");
   a_st_hold: assert property (
      (ctrl_m[0] && !int_n) |=> (!int_n || !ctrl_m[0]))
      else $error("self test interrupt dropped with run bit set");
   a_parity_off: assert property (
      (mask_m == 16'h0001 && ctrl_m == 4'h0 && int_n && !acc_w) |=> int_n)
      else $error("parity event with checking disabled");
   a_sd_rise: assert property (
      (ce && mask_m == 16'h4000 && !ctrl_m[0] && $rose(signal_detect_pin))
      |-> ##[1:4] !int_n) else $error("signal detect did not interrupt");
   c_flag_read: cover property (ce && avs_read && !avs_waitrequest
      && idx == 6'h17);
   c_st_int: cover property (ctrl_m[0] && !int_n);
   c_ev_int: cover property (!ctrl_m[0] && !int_n);
endmodule

bind pei_unit pei_props u_props (.clk_sys, .rst, .ce, .avs_address, .avs_read,
   .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .int_n, .signal_detect_pin, .self_test_complete);

// [bench/tb_top.sv]
// self-checking bench of the event interrupt unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst, ce, int_n, avs_read, avs_write, avs_waitrequest;
   logic        signal_detect_pin, self_test_complete, vector_write_strobe;
   logic        phase_timer_write, noise_timer_write, pcm_signaling;
   logic        upkeep_state, noise_timing_flag, idle_min_lowered;
   logic        idle_gap_inc, idle_gap_ovf, violation_inc, violation_ovf;
   logic        phy_invalid, elastic_overflow, elastic_underflow, pcm_break;
   logic        noise_duration_expiry, connection_phase_expiry, pcm_active;
   logic        scrub_join_signal, scrub_done, pcm_trace, vector_done;
   logic        lct_done, receive_complete_flag, line_quiet, line_halt;
   logic        line_master;
   logic [2:0]  line_state;
   logic [3:0]  avs_byteenable;
   logic [7:0]  avs_address, link_error_count;
   logic [9:0]  tx_data;
   logic [15:0] lf;
   logic [31:0] avs_writedata, avs_readdata, pat, rdv;
   int          err_count = 0;
   int          check_count = 0;
   // {control, stimulus word, expected flags}
   logic [51:0] tbl [$] = '{
   52'h0_00000002_2000, 52'h0_00000001_4000, 52'h0_00000004_1000,
   52'h0_00000008_1000, 52'h0_00000010_0000, 52'h2_00000010_1000,
   52'h0_00000020_0800, 52'h0_00000040_0000, 52'h4_00000040_0800,
   52'h0_00000080_0400, 52'h0_00000100_0200, 52'h0_00000200_0200,
   52'h0_00000400_0100, 52'h0_00000800_0080, 52'h0_00007000_0040,
   52'h0_00008000_0020, 52'h0_00210000_0010, 52'h0_00410000_0010,
   52'h0_00804000_0008, 52'h0_00810000_0008, 52'h0_00020000_0000,
   52'h0_00080000_0004, 52'h0_00040000_0004, 52'h0_00100000_0002,
   52'h0_01000000_0000, 52'h8_01000000_0001, 52'h0_02000000_8000,
   52'h0_22000000_0000, 52'h0_64000000_8000, 52'h0_18000000_8000};
   pei_unit DUT (.clk_sys, .rst, .ce, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .int_n,
      .signal_detect_pin, .vector_write_strobe, .phase_timer_write,
      .noise_timer_write, .pcm_signaling, .upkeep_state, .noise_timing_flag,
      .link_error_count, .idle_min_lowered, .idle_gap_inc, .idle_gap_ovf,
      .violation_inc, .violation_ovf, .phy_invalid, .elastic_overflow,
      .elastic_underflow, .noise_duration_expiry, .connection_phase_expiry,
      .scrub_join_signal, .scrub_done, .pcm_active, .pcm_break, .pcm_trace,
      .vector_done, .lct_done, .receive_complete_flag, .line_state,
      .line_quiet, .line_halt, .line_master, .tx_data, .self_test_complete);
   pei_np np (.clk_sys, .avs_address, .avs_read, .avs_write, .avs_byteenable,
      .avs_writedata, .avs_readdata, .avs_waitrequest);
   // one stimulus word drives every event source
   assign signal_detect_pin = pat[0];
   assign link_error_count  = pat[1] ? 8'h5A : 8'h01;
   assign {violation_ovf, violation_inc, idle_gap_ovf, idle_gap_inc,
           idle_min_lowered} = pat[6:2];
   assign {connection_phase_expiry, noise_duration_expiry, elastic_underflow,
           elastic_overflow, phy_invalid} = pat[11:7];
   assign {pcm_break, pcm_active, scrub_done, scrub_join_signal} = pat[15:12];
   assign {receive_complete_flag, lct_done, vector_done,
           pcm_trace} = pat[19:16];
   assign line_state = pat[20] ? 3'h5 : 3'h2;
   assign {line_master, line_halt, line_quiet} = pat[23:21];
   // random data keeps good parity unless an error is asked for
   assign tx_data = pat[24] ? 10'h000 : {lf[8:0], ~^lf[8:0]};
   assign {noise_timing_flag, upkeep_state, pcm_signaling, vector_write_strobe,
           noise_timer_write, phase_timer_write} = pat[30:25];
   assign self_test_complete = pat[31];
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic int_expect(input logic [15:0] ev,
                                       input logic [15:0] m);
      return ~|(ev & m);
   endfunction
   always @(posedge clk_sys) lf <= lfsr_next(lf);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic pulse(input logic [31:0] p, input int n);
      pat <= p;
      repeat (n) @(posedge clk_sys);
      pat <= 32'h0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic run_ent(input int i);
      logic [51:0] e;
      logic [15:0] m;
      e = tbl[i];
      m = (e[15:0] == 16'h0000) ? 16'h0001 : (i[0] ? e[15:0] : lf);
      np.xfer(6'h00, 1'b1, {12'h000, e[51:48]}, rdv);
      np.xfer(6'h02, 1'b1, m, rdv);
      pulse(e[47:16], 4);
      chk(int_n, int_expect(e[15:0], m));
      np.svc(rdv);
      chk(rdv, e[15:0]);
      np.svc(rdv);
      chk(rdv, 32'h0);
      chk(int_n, 1'b1);
      $display("event test %0d done", i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      end_of_test();
   end
   initial begin
      lf = 16'h5357;
      pat = 32'h0;
      ce = 1'b1;
      rst = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({avs_waitrequest, int_n}, 2'h3);
      np.xfer(6'h02, 1'b0, 16'h0000, rdv);
      chk(rdv, 32'h0);
      np.svc(rdv);
      chk(rdv, 32'h0);
      np.xfer(6'h3F, 1'b0, 16'h0000, rdv);
      chk(rdv, 32'h0);
      np.xfer(6'h02, 1'b1, lf, rdv);
      np.xfer(6'h05, 1'b1, 16'h005A, rdv);
      np.xfer(6'h01, 1'b1, 16'h0005, rdv);
      np.xfer(6'h05, 1'b0, 16'h0000, rdv);
      chk(rdv, 32'h0000_005A);
      np.xfer(6'h01, 1'b0, 16'h0000, rdv);
      chk(rdv, 32'h0000_0005);
      np.xfer(6'h17, 1'b1, 16'hFFFF, rdv);
      np.svc(rdv);
      chk(rdv, 32'h8000);
      $display("register test done");
      foreach (tbl[i]) run_ent(i);
      // frozen enable: events seen while ce is low leave no trace
      ce <= 1'b0;
      pulse(32'h0000_0101, 2);
      ce <= 1'b1;
      np.svc(rdv);
      chk(rdv, 32'h0);
      $display("clock enable test done");
      // self test: flags still latch but only completion reaches the pin
      np.xfer(6'h02, 1'b1, 16'hFFFF, rdv);
      np.xfer(6'h00, 1'b1, 16'h0001, rdv);
      pulse(32'h0000_0100, 1);
      chk(int_n, 1'b1);
      pulse(32'h8000_0000, 1);
      chk(int_n, 1'b0);
      np.svc(rdv);
      chk(rdv, 32'h0200);
      @(posedge clk_sys);
      chk(int_n, 1'b0);
      np.xfer(6'h00, 1'b1, 16'h0000, rdv);
      @(posedge clk_sys);
      chk(int_n, 1'b1);
      $display("self test done");
      // mid-run reset must drop a pending flag and the mask again
      np.xfer(6'h17, 1'b1, 16'h0000, rdv);
      @(posedge clk_sys);
      chk(int_n, 1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({avs_waitrequest, int_n}, 2'h3);
      np.xfer(6'h02, 1'b0, 16'h0000, rdv);
      chk(rdv, 32'h0);
      np.svc(rdv);
      chk(rdv, 32'h0);
      $display("reset test done");
      end_of_test();
   end
endmodule

// [rtl/pei_defines.svh]
// register indices, field positions, reset values of the event interrupt unit
`ifndef PEI_DEFINES_SVH
`define PEI_DEFINES_SVH

// register indices, byte address is four times the index
`define PEI_IDX_FIRST_CTRL   6'h00
`define PEI_IDX_SECOND_CTRL  6'h01
`define PEI_IDX_MASK         6'h02
`define PEI_IDX_LE_LIMIT     6'h05
`define PEI_IDX_EVENTS       6'h17

// event bit positions
`define PEI_EV_INVALID       15
`define PEI_EV_SIG_DETECT    14
`define PEI_EV_LINK_ERR      13
`define PEI_EV_IDLE_GAP      12
`define PEI_EV_VIOLATION     11
`define PEI_EV_PHY_INVALID   10
`define PEI_EV_EBUF          9
`define PEI_EV_NOISE_EXP     8
`define PEI_EV_PHASE_EXP     7
`define PEI_EV_PCM_ENABLED   6
`define PEI_EV_PCM_BREAK     5
`define PEI_EV_TRACE_QH      4
`define PEI_EV_MASTER        3
`define PEI_EV_PCM_CODE      2
`define PEI_EV_LS_EQUAL      1
`define PEI_EV_PARITY        0

// first control register fields
`define PEI_CA_RUN_SELF_TEST 0
`define PEI_CA_IDLE_SEL      1
`define PEI_CA_VIOL_SEL      2
`define PEI_CA_PAR_CHK_EN    3

// widths
`define PEI_EV_W             16
`define PEI_CA_W             4
`define PEI_LS_W             3
`define PEI_LE_W             8
`define PEI_RISE_W           9

// reset values
`define PEI_FLAGS_RST        16'h0000
`define PEI_MASK_RST         16'h0000
`define PEI_CA_RST           4'h0
`define PEI_LS_RST           3'h0
`define PEI_LE_RST           8'h00
`define PEI_RDATA_RST        32'h0000_0000

`endif

// [rtl/pei_pkg.sv]
// types of the event interrupt unit
package pei_pkg;

   typedef struct packed {
      logic [1:0]  sd_sync;
      logic [15:0] flags;
      logic [15:0] mask;
      logic [3:0]  ctrl_a;
      logic [2:0]  ls_cmp;
      logic [7:0]  le_limit;
      logic        st_pending;
      logic        code_pending;
      logic        waitreq;
      logic [31:0] rdata;
      logic        int_n;
   } pei_state_t;

   typedef struct packed {
      logic [8:0] prev;
   } pei_rise_state_t;

endpackage

// [rtl/pei_rise.sv]
// per-bit rising edge detector over a vector of levels
`include "pei_defines.svh"

module pei_rise #(
   parameter int WIDTH = `PEI_RISE_W
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             ce,
   // levels in, one-cycle rises out
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;

   always_comb begin
      next_prev = level;
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign rise[i] = level[i] & ~prev[i];
      end
   endgenerate

   // reset as zero: a level already high at release counts as a rise
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev <= '0;
      end else if (ce) begin
         prev <= next_prev;
      end
   end

endmodule

// [rtl/pei_unit.sv]
// event flag register, mask and interrupt pin of the physical layer controller
//
// Behaviour
// - event register at index 17 hex; a read of it clears the bits it returned, reset clears all.
// - while self test runs, only its completion may drive the interrupt pin.
// - completion interrupt holds until software clears the run self test bit.
// - bit 15 flags invalid accesses: read-only writes, locked timer writes.
// - bit 14 sets when the signal detect pin becomes asserted.
// - bit 13 sets when link error count reaches the programmed limit.
// - bit 12: idle minimum lowered, or selected gap increment or overflow.
// - bit 11: violation counter increment or overflow, chosen by select bit.
// - bit 10 sets when physical invalid indication becomes asserted.
// - bit 9 sets on elasticity buffer overflow or underflow.
// - bit 8 on noise timer expiry, bit 7 on phase timer expiry.
// - bit 6 when scrub join, scrub done and active state all hold.
// - bit 5 when the connection manager enters its break state.
// - bit 4 on quiet or halt line state during trace state.
// - bit 3 on master line state during active or trace state.
// - bit 2 on test done, or vector done then receive flag set again.
// - bit 1 when detected line state equals the programmed compare field.
// - bit 0 on transmit parity error, only with parity check enabled.
// - mask at index 02 hex; a set bit lets its event drive the pin.
// - event bits set and clear the same whatever the mask holds.
// - mask clears at reset, so nothing interrupts until software enables.
`include "pei_defines.svh"

module pei_unit #(
   parameter bit ODD_PARITY = 1'b1
) (
   // clock, reset, enable
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // interrupt pin toward the node processor
   output logic             int_n,
   // asynchronous pin
   input  wire logic        signal_detect_pin,
   // accesses checked elsewhere in the controller
   input  wire logic        vector_write_strobe,
   input  wire logic        phase_timer_write,
   input  wire logic        noise_timer_write,
   input  wire logic        pcm_signaling,
   input  wire logic        upkeep_state,
   input  wire logic        noise_timing_flag,
   // counters
   input  wire logic [7:0]  link_error_count,
   input  wire logic        idle_min_lowered,
   input  wire logic        idle_gap_inc,
   input  wire logic        idle_gap_ovf,
   input  wire logic        violation_inc,
   input  wire logic        violation_ovf,
   // physical layer status
   input  wire logic        phy_invalid,
   input  wire logic        elastic_overflow,
   input  wire logic        elastic_underflow,
   input  wire logic        noise_duration_expiry,
   input  wire logic        connection_phase_expiry,
   // connection manager status
   input  wire logic        scrub_join_signal,
   input  wire logic        scrub_done,
   input  wire logic        pcm_active,
   input  wire logic        pcm_break,
   input  wire logic        pcm_trace,
   input  wire logic        vector_done,
   input  wire logic        lct_done,
   input  wire logic        receive_complete_flag,
   // line state
   input  wire logic [2:0]  line_state,
   input  wire logic        line_quiet,
   input  wire logic        line_halt,
   input  wire logic        line_master,
   // transmit data from the mac
   input  wire logic [9:0]  tx_data,
   // self test
   input  wire logic        self_test_complete
);

   localparam pei_pkg::pei_state_t RESET_STATE = '{
      sd_sync:      2'h0,
      flags:        `PEI_FLAGS_RST,
      mask:         `PEI_MASK_RST,
      ctrl_a:       `PEI_CA_RST,
      ls_cmp:       `PEI_LS_RST,
      le_limit:     `PEI_LE_RST,
      st_pending:   1'b0,
      code_pending: 1'b0,
      waitreq:      1'b1,
      rdata:        `PEI_RDATA_RST,
      int_n:        1'b1
   };

   pei_pkg::pei_state_t s;
   pei_pkg::pei_state_t next_s;

   logic [`PEI_RISE_W-1:0] levels;
   logic [`PEI_RISE_W-1:0] rises;
   logic [5:0]             idx;
   logic                   req;
   logic                   accept;
   logic                   run;
   logic [`PEI_EV_W-1:0]   ev;
   logic [`PEI_EV_W-1:0]   clr;
   logic [15:0]            wmask;
   logic [15:0]            wdata;
   logic [31:0]            rmux;
   logic                   par_bad;

   assign idx    = avs_address[7:2];
   assign req    = avs_read | avs_write;
   assign accept = req & ~s.waitreq;
   assign run    = s.ctrl_a[`PEI_CA_RUN_SELF_TEST];
   assign wdata  = avs_writedata[15:0];
   assign wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // only the second synchroniser stage is watched for edges
   assign levels[0] = s.sd_sync[1];
   assign levels[1] = phy_invalid;
   assign levels[2] = (link_error_count == s.le_limit);
   assign levels[3] = scrub_join_signal & scrub_done & pcm_active;
   assign levels[4] = pcm_break;
   assign levels[5] = pcm_trace & (line_quiet | line_halt);
   assign levels[6] = (pcm_active | pcm_trace) & line_master;
   assign levels[7] = (line_state == s.ls_cmp);
   assign levels[8] = receive_complete_flag;

   pei_rise #(
      .WIDTH(`PEI_RISE_W)
   ) u_rise (
      .clk_sys(clk_sys),
      .rst    (rst),
      .ce     (ce),
      .level  (levels),
      .rise   (rises)
   );

   // parity sense is a parameter, the pins carry data and parity together
   assign par_bad = (^tx_data) != ODD_PARITY;

   always_comb begin
      rmux = 32'h0000_0000;
      unique case (idx)
         `PEI_IDX_FIRST_CTRL:  rmux[`PEI_CA_W-1:0] = s.ctrl_a;
         `PEI_IDX_SECOND_CTRL: rmux[`PEI_LS_W-1:0] = s.ls_cmp;
         `PEI_IDX_MASK:        rmux[`PEI_EV_W-1:0] = s.mask;
         `PEI_IDX_LE_LIMIT:    rmux[`PEI_LE_W-1:0] = s.le_limit;
         `PEI_IDX_EVENTS:      rmux[`PEI_EV_W-1:0] = s.flags;
         default:              rmux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_s = s;
      ev     = '0;
      clr    = '0;

      next_s.sd_sync = {s.sd_sync[0], signal_detect_pin};

      // event sources
      ev[`PEI_EV_INVALID] =
         (accept & avs_write & (idx == `PEI_IDX_EVENTS)) |
         (vector_write_strobe & pcm_signaling) |
         (phase_timer_write & ~upkeep_state) |
         (noise_timer_write & (~upkeep_state | noise_timing_flag));
      ev[`PEI_EV_SIG_DETECT] = rises[0];
      ev[`PEI_EV_LINK_ERR]   = rises[2];
      ev[`PEI_EV_IDLE_GAP]   = idle_min_lowered |
         (s.ctrl_a[`PEI_CA_IDLE_SEL] ? idle_gap_ovf : idle_gap_inc);
      ev[`PEI_EV_VIOLATION]  = s.ctrl_a[`PEI_CA_VIOL_SEL] ?
         violation_ovf : violation_inc;
      ev[`PEI_EV_PHY_INVALID] = rises[1];
      ev[`PEI_EV_EBUF] = elastic_overflow | elastic_underflow;
      ev[`PEI_EV_NOISE_EXP]  = noise_duration_expiry;
      ev[`PEI_EV_PHASE_EXP]  = connection_phase_expiry;
      ev[`PEI_EV_PCM_ENABLED] = rises[3];
      ev[`PEI_EV_PCM_BREAK]  = rises[4];
      ev[`PEI_EV_TRACE_QH]   = rises[5];
      ev[`PEI_EV_MASTER]     = rises[6];
      ev[`PEI_EV_LS_EQUAL]   = rises[7];
      ev[`PEI_EV_PARITY] = par_bad & s.ctrl_a[`PEI_CA_PAR_CHK_EN];

      // signalling completion waits for the receive flag to rise again
      ev[`PEI_EV_PCM_CODE] = lct_done | (s.code_pending & rises[8]);
      if (vector_done) begin
         next_s.code_pending = 1'b1;
      end else if (s.code_pending & rises[8]) begin
         next_s.code_pending = 1'b0;
      end

      // bus: one wait cycle, data captured first, effect at the accept edge
      if (req & s.waitreq) begin
         next_s.waitreq = 1'b0;
         next_s.rdata   = rmux;
      end else if (accept) begin
         next_s.waitreq = 1'b1;
      end

      // clear only what the read returned, so later events survive
      if (accept & avs_read & (idx == `PEI_IDX_EVENTS)) begin
         clr = s.rdata[`PEI_EV_W-1:0];
      end

      if (accept & avs_write) begin
         unique case (idx)
            `PEI_IDX_FIRST_CTRL: begin
               if (avs_byteenable[0]) begin
                  next_s.ctrl_a = wdata[`PEI_CA_W-1:0];
               end
            end
            `PEI_IDX_SECOND_CTRL: begin
               if (avs_byteenable[0]) begin
                  next_s.ls_cmp = wdata[`PEI_LS_W-1:0];
               end
            end
            `PEI_IDX_MASK: begin
               next_s.mask = (s.mask & ~wmask) | (wdata & wmask);
            end
            `PEI_IDX_LE_LIMIT: begin
               if (avs_byteenable[0]) begin
                  next_s.le_limit = wdata[`PEI_LE_W-1:0];
               end
            end
            default: begin
               next_s.mask = next_s.mask;
            end
         endcase
      end

      // flags ignore the mask; a new event beats a clear
      next_s.flags = (s.flags & ~clr) | ev;

      // completion latches while running, goes only with the run bit
      if (!next_s.ctrl_a[`PEI_CA_RUN_SELF_TEST]) begin
         next_s.st_pending = 1'b0;
      end else if (run & self_test_complete) begin
         next_s.st_pending = 1'b1;
      end

      // self test hides every flag from the pin
      if (next_s.ctrl_a[`PEI_CA_RUN_SELF_TEST]) begin
         next_s.int_n = ~next_s.st_pending;
      end else begin
         next_s.int_n = ~|(next_s.flags & next_s.mask);
      end
   end

   // mask reset to zero keeps the pin quiet until enabled
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= RESET_STATE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign int_n           = s.int_n;

endmodule
